// ===== src/rgc_cfg.svh
`ifndef RGC_CFG_SVH
`define RGC_CFG_SVH
`define RGC_IDX_GAIN_STATE   6'h2d
`define RGC_IDX_CS_CTRL      6'h2e
`define RGC_IDX_CS_DISP      6'h2f
`define RGC_IDX_IRQ_STATUS   6'h30
`define RGC_IDX_IRQ_MASK     6'h31
`define RGC_IDX_COMMAND      6'h32
`define RGC_IDX_RSSI_CODE    6'h33
`define RGC_RESET_VALUE      8'h00
`define RGC_TRIM_MSB         7
`define RGC_TRIM_LSB         3
`define RGC_GAIN_MSB         2
`define RGC_GAIN_LSB         0
`define RGC_DONE_BIT         2
`define RGC_ERR_BIT          1
`define RGC_IRQ_DONE_BIT     0
`define RGC_IRQ_ERR_BIT      1
`define RGC_CMD_SET_DEFAULT  8'hc1
`define RGC_CMD_START_TRIM   8'hc2
`define RGC_TRIM_STEP_FF     1
`define RGC_TRIM_MAX_FF      31
`define RGC_RSSI_TOP_CODE    4'hd
`endif

// ===== src/rgc_pkg.sv
package rgc_pkg;
  typedef enum logic [2:0] {
    GAIN_2P8  = 3'h0,
    GAIN_6P5  = 3'h1,
    GAIN_1P1  = 3'h2,
    GAIN_0P5  = 3'h4,
    GAIN_0P35 = 3'h6
  } rgc_gain_type;
  typedef enum {TRIM_IDLE, TRIM_RUN} rgc_trim_state_type;
endpackage : rgc_pkg

// ===== src/rgc_rssi_coder.sv
`timescale 1ns/1ps
`include "rgc_cfg.svh"
// level thresholds in mV rms; codes above the top bucket never produced
module rgc_rssi_coder (
  input  wire logic [9:0] level_mv,
  output logic      [3:0] code
);
  localparam logic [9:0] THR [0:12] = '{10'd20, 10'd27, 10'd37, 10'd52, 10'd72, 10'd99, 10'd136,
                                        10'd190, 10'd262, 10'd357, 10'd500, 10'd686, 10'd950};
  always_comb begin
    code = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (level_mv > THR[i]) code = 4'(i + 1);
    end
  end
endmodule : rgc_rssi_coder

// ===== src/rgc_regs.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "rgc_cfg.svh"
module rgc_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  amplitude_channel_gain_cut,
  input  wire logic [3:0]  phase_channel_gain_cut,
  input  wire logic [9:0]  receiver_input_one_mv,
  input  wire logic        trim_done,
  input  wire logic        trim_valid,
  input  wire logic [4:0]  trim_result,
  output logic             trim_start,
  output logic             trim_auto,
  output logic      [4:0]  trim_manual,
  output logic      [2:0]  sensor_gain,
  output logic             irq
);
  wire        acc      = psel & penable & ~pready;
  wire        wr       = acc & pwrite;
  wire        rd       = acc & ~pwrite;
  wire [5:0]  idx      = paddr[7:2];
  wire        aligned  = (paddr[1:0] == 2'b00) && (paddr[11:8] == 4'h0);
  wire        hit_gs   = aligned && idx == `RGC_IDX_GAIN_STATE;
  wire        hit_ctl  = aligned && idx == `RGC_IDX_CS_CTRL;
  wire        hit_dsp  = aligned && idx == `RGC_IDX_CS_DISP;
  wire        hit_ist  = aligned && idx == `RGC_IDX_IRQ_STATUS;
  wire        hit_msk  = aligned && idx == `RGC_IDX_IRQ_MASK;
  wire        hit_cmd  = aligned && idx == `RGC_IDX_COMMAND;
  wire        hit_rsi  = aligned && idx == `RGC_IDX_RSSI_CODE;
  wire        mapped   = hit_gs | hit_ctl | hit_dsp | hit_ist | hit_msk | hit_cmd | hit_rsi;
  wire        set_def  = wr && hit_cmd && pwdata[7:0] == `RGC_CMD_SET_DEFAULT;
  wire        go_trim  = wr && hit_cmd && pwdata[7:0] == `RGC_CMD_START_TRIM;
  logic [7:0] gs_q;
  logic [7:0] ctl_q;
  logic [7:0] dsp_q;
  logic [1:0] ist_q;
  logic [1:0] msk_q;
  logic [3:0] rssi_q;
  logic [3:0] rssi_code;
  rgc_pkg::rgc_trim_state_type st_q;
  rgc_rssi_coder u_rssi (
    .level_mv (receiver_input_one_mv),
    .code     (rssi_code)
  );
  wire [4:0]  man      = ctl_q[`RGC_TRIM_MSB:`RGC_TRIM_LSB];
  wire        is_auto  = (man == 5'h00);
  wire        fin      = (st_q == rgc_pkg::TRIM_RUN) && trim_done;
  // a trim result of zero is also treated as no valid trim
  wire        bad      = ~trim_valid | (trim_result == 5'h00);
  wire [1:0]  ev       = {fin & bad, fin};
  wire [7:0]  rd_mux   = hit_gs  ? gs_q :
                         hit_ctl ? ctl_q :
                         hit_dsp ? dsp_q :
                         hit_ist ? {6'h00, ist_q} :
                         hit_msk ? {6'h00, msk_q} :
                         hit_rsi ? {4'h0, rssi_q} : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gs_q   <= `RGC_RESET_VALUE;
      rssi_q <= 4'h0;
    end else if (set_def) begin
      gs_q   <= `RGC_RESET_VALUE;
      rssi_q <= 4'h0;
    end else begin
      gs_q   <= {amplitude_channel_gain_cut, phase_channel_gain_cut};
      rssi_q <= rssi_code;
    end
  end
  // unused gain codes are kept as written; the analog side must ignore them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= `RGC_RESET_VALUE;
    else if (set_def) ctl_q <= `RGC_RESET_VALUE;
    else if (wr && hit_ctl) ctl_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsp_q <= `RGC_RESET_VALUE;
      st_q  <= rgc_pkg::TRIM_IDLE;
    end else if (set_def) begin
      dsp_q <= `RGC_RESET_VALUE;
      st_q  <= rgc_pkg::TRIM_IDLE;
    end else begin
      case (st_q)
        rgc_pkg::TRIM_IDLE: begin
          if (go_trim && is_auto) begin
            st_q  <= rgc_pkg::TRIM_RUN;
            dsp_q <= `RGC_RESET_VALUE;
          end
        end
        rgc_pkg::TRIM_RUN: begin
          if (trim_done) begin
            st_q  <= rgc_pkg::TRIM_IDLE;
            dsp_q <= {trim_result, 1'b1, bad, 1'b0};
          end
        end
        default: st_q <= rgc_pkg::TRIM_IDLE;
      endcase
    end
  end
  // set beats clear so a finishing trim is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 2'b00;
      msk_q <= 2'b00;
    end else begin
      ist_q <= (ist_q & ~((wr && hit_ist) ? pwdata[1:0] : 2'b00)) | ev;
      if (wr && hit_msk) msk_q <= pwdata[1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq         <= 1'b0;
      trim_start  <= 1'b0;
      trim_auto   <= 1'b1;
      trim_manual <= 5'h00;
      sensor_gain <= 3'h0;
    end else begin
      irq         <= |(ist_q & msk_q);
      trim_start  <= go_trim && is_auto && st_q == rgc_pkg::TRIM_IDLE && !set_def;
      trim_auto   <= is_auto;
      trim_manual <= man;
      sensor_gain <= ctl_q[`RGC_GAIN_MSB:`RGC_GAIN_LSB];
    end
  end
endmodule : rgc_regs

// ===== testbench/rgc_regs_assertions.sv
`timescale 1ns/1ps
module rgc_regs_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trim_start,
  input wire logic        trim_auto,
  input wire logic [4:0]  trim_manual
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  property p_ans; s_acc |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("access answer not one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_disp; pready && !pwrite && paddr == 12'hbc |-> !prdata[0]; endproperty
  a_disp: assert property (p_disp) else $error("display bit 0 set");
  property p_auto; trim_auto == (trim_manual == 5'h0); endproperty
  a_auto: assert property (p_auto) else $error("auto flag disagrees with trim");
  property p_go; trim_start |-> trim_auto; endproperty
  a_go: assert property (p_go) else $error("trim start in manual mode");
  property p_pulse; trim_start |=> !trim_start; endproperty
  a_pulse: assert property (p_pulse) else $error("trim start too long");
  property p_rst; $rose(presetn) |-> trim_auto && trim_manual == 5'h0 && !trim_start; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule : rgc_regs_assertions
bind rgc_regs rgc_regs_assertions rgc_regs_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .trim_start, .trim_auto, .trim_manual);

// ===== testbench/rgc_regs_test.sv
`timescale 1ns/1ps
module rgc_regs_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trim_done = 0, trim_valid = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, lf = 32'h25ec;
  logic [3:0]  amplitude_channel_gain_cut = 4'h0, phase_channel_gain_cut = 4'h0;
  logic [9:0]  receiver_input_one_mv = 10'h0;
  logic [4:0]  trim_result = 5'h0, trim_manual;
  logic [2:0]  sensor_gain, gc[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
  logic        pready, pslverr, trim_start, trim_auto, irq, e, er;
  int          fail_count = 0, tests_run = 0, starts = 0;
  int          th[13] = '{20, 27, 37, 52, 72, 99, 136, 190, 262, 357, 500, 686, 950};
  rgc_regs rgc_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .amplitude_channel_gain_cut, .phase_channel_gain_cut, .receiver_input_one_mv, .trim_done, .trim_valid,
    .trim_result, .trim_start, .trim_auto, .trim_manual, .sensor_gain, .irq);
  initial forever #4 pclk = ~pclk;
  always @(posedge pclk) if (trim_start === 1'b1) starts++;
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) begin
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    end
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    #60000;
    fail_count++;
    summarize;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'hb8, 0); chk("ctrl_reset", 0, r);
    apb(0, 12'hbc, 0); chk("disp_reset", 0, r);
    lf = rnd(lf);
    {amplitude_channel_gain_cut, phase_channel_gain_cut} <= lf[7:0];
    apb(1, 12'hb4, 32'hff); // read-only, write dropped
    apb(0, 12'hb4, 0); chk("gain_state", {24'h0, lf[7:0]}, r);
    for (int i = 0; i < 26; i++) begin
      receiver_input_one_mv <= 10'(th[i / 2] + i % 2);
      apb(0, 12'hcc, 0); chk("rssi", i / 2 + i % 2, r);
    end
    foreach (gc[i]) begin
      lf = rnd(lf);
      apb(1, 12'hb8, {24'h0, lf[4:0], gc[i]});
      apb(0, 12'hb8, 0); chk("ctrl", {24'h0, lf[4:0], gc[i]}, r);
      chk("gain_out", gc[i], sensor_gain);
      chk("trim_out", lf[4:0], trim_manual);
      chk("auto_out", lf[4:0] == 5'h0, trim_auto);
    end
    // first run masked and invalid, second unmasked and valid
    for (int k = 0; k < 2; k++) begin
      lf = rnd(lf);
      er = k == 0 || lf[4:0] == 5'h0;
      apb(1, 12'hc4, k * 3);
      apb(1, 12'hb8, 0);
      apb(1, 12'hc8, 32'hc2);
      repeat (2) @(posedge pclk);
      {trim_done, trim_valid, trim_result} <= {1'b1, k[0], lf[4:0]};
      @(posedge pclk) trim_done <= 1'b0;
      apb(0, 12'hbc, 0); chk("display", {24'h0, lf[4:0], 1'b1, er, 1'b0}, r);
      apb(0, 12'hc0, 0); chk("status", {30'h0, er, 1'b1}, r);
      chk("irq", k, irq);
      apb(1, 12'hc0, 3);
      apb(0, 12'hc0, 0); chk("status_clear", 0, r);
      chk("irq_clear", 0, irq);
    end
    chk("starts", 2, starts);
    apb(0, 12'hfc, 0); chk("unmapped", 1, e);
    apb(1, 12'hb8, 32'hff);
    apb(1, 12'hc8, 32'hc1);
    apb(0, 12'hb8, 0); chk("ctrl_default", 0, r);
    apb(0, 12'hbc, 0); chk("disp_default", 0, r);
    summarize;
  end
endmodule : rgc_regs_test
